/* rtl/simd_fp_gate_pkg.sv */
/*
 * constants, field layouts and encodings for the vector fault gate.
 * assumes a 32-bit ahb-lite register bus and a single core clock.
 */
// What this block does
// [RL1] packed integer vector ops raise no numeric condition
// [RL2] six numeric conditions, each masked on its own
// [RL3] masked condition: default result, no fault
// [RL4] unmasked condition raises vector floating-point fault
// [RL5] numeric-error select and ignore pin have no effect
// [RL6] vector op under emulate flag: undefined-opcode fault
// [RL7] switched flag: unit-unavailable fault before execution
// [RL8] no unit-unavailable fault without such an instruction
// [RL9] hardware task switch sets switched flag
// [RL10] move to control register zero sets flag
// [RL11] handler clears switched flag after saving state
// [RL12] software sets handler-present flag, bit 10
// [RL13] full save/restore moves eight vectors, status, scalar
// [RL14] system software uses full save/restore on switches
// [RL15] alt save: eight quad moves then status store
// [RL16] alt restore: reload vectors then status load
// [RL17] software sets switched flag by state ownership
// [RL18] handler saves, restores, records owner, clears flag
// [RL19] no handler flag: unmasked condition gives undefined-opcode
// [RL20] emulate flag bit 2 overrides switched flag
// [RL21] switched flag bit 3 blocks vector instructions
// [RL22] gating decided before any state changes
package simd_fp_gate_pkg;
    // ==========================================================
    // register map (byte offsets)
    localparam logic [7:0] OFF_CTRL0   = 8'h00; // control_reg_zero
    localparam logic [7:0] OFF_CTRL4   = 8'h04; // control_reg_four
    localparam logic [7:0] OFF_VCSR    = 8'h08; // vector ctl/status
    localparam logic [7:0] OFF_FAULTS  = 8'h0c; // last fault, ro
    // ==========================================================
    // field positions
    localparam int BIT_EMULATE  = 2;   // emulate_flag
    localparam int BIT_SWITCHED = 3;   // task_switched_flag
    localparam int BIT_NUM_SEL  = 5;   // numeric_error_select
    localparam int BIT_OS_HNDL  = 10;  // os_vector_handler_flag
    localparam int NUM_COND     = 6;   // numeric conditions
    localparam int VCS_FLAG_LSB = 0;   // sticky condition flags
    localparam int VCS_MASK_LSB = 7;   // condition masks
    // ==========================================================
    // reset values and status write mask
    localparam logic [31:0] CTRL0_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL4_RESET = 32'h0000_0000;
    localparam logic [31:0] VCSR_RESET  = 32'h0000_0000;
    localparam logic [31:0] VCSR_WMASK  = 32'h0000_ffff;
    // ==========================================================
    // full-state transfer: vectors 0..7, status, scalar state
    localparam logic [3:0] XFER_VEC_LAST = 4'h7;
    localparam logic [3:0] XFER_VCS_ITEM = 4'h8;
    localparam logic [3:0] XFER_SCL_ITEM = 4'h9;
    // ==========================================================
    // decoded instruction kind
    typedef enum logic [4:0] {
        KIND_LEGACY  = 5'h01,  // scalar fp or packed integer legacy
        KIND_VEC_INT = 5'h02,  // packed integer vector
        KIND_VEC_FP  = 5'h04,  // packed/scalar vector fp
        KIND_SAVE    = 5'h08,  // full_state_save_op
        KIND_RESTORE = 5'h10   // full_state_restore_op
    } kind_t;
    // fault codes
    typedef enum logic [2:0] {
        FAULT_NONE    = 3'h0,
        FAULT_VEC_FP  = 3'h1,  // vector_fp_fault
        FAULT_UNDEF   = 3'h2,  // undefined_opcode_fault
        FAULT_UNAVAIL = 3'h4   // unit_unavailable_fault
    } fault_t;
    // transfer sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_state_t;
endpackage

/* rtl/simd_fp_gate.sv */
/*
 * vector floating-point fault gating for one core, with the two
 * control registers, the vector control/status register, a fault
 * record and the full-state transfer sequencer.
 * assumes decode presents one instruction per cycle from the core
 * clock domain and the datapath reports raw conditions with it.
 */
// Chosen here: the AHB-Lite register port and the placing of the registers.
module simd_fp_gate (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [7:0]             haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // issue from decode
    input  wire logic                   issue_valid,
    input  simd_fp_gate_pkg::kind_t     issue_kind,
    input  wire logic [5:0]             issue_cond,
    // control register zero side effects
    input  wire logic                   hw_task_switch,
    input  wire logic                   mov_cr0_valid,
    input  wire logic [31:0]            mov_cr0_data,
    input  wire logic                   clear_switched_flag_op_valid,
    // outcome toward retire
    output logic                        out_valid,
    output simd_fp_gate_pkg::fault_t    out_fault,
    output logic                        out_commit,
    output logic                        out_default,
    // full-state transfer
    output logic                        xfer_busy,
    output logic                        xfer_valid,
    output logic                        xfer_store,
    output logic [3:0]                  xfer_item,
    output logic [31:0]                 xfer_wdata,
    input  wire logic [31:0]            xfer_rdata
);
    import simd_fp_gate_pkg::*;

    // ==========================================================
    // bus slave
    logic        ph_wr;      // write data phase pending
    logic [7:0]  ph_addr;    // captured address
    logic        take_bus;   // address phase accepted
    logic [31:0] ctrl0;      // control_reg_zero
    logic [31:0] ctrl4;      // control_reg_four
    logic [31:0] vcsr;       // vector_control_status_reg
    logic [31:0] faults;     // last fault code and count

    assign take_bus = hsel && htrans[1] && hready;

    // zero wait state, always okay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // capture write address phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_wr   <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr   <= take_bus && hwrite && hsize == 3'h2;
            ph_addr <= take_bus ? haddr : ph_addr;
        end
    end

    // read data latched in the address phase, unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take_bus && !hwrite) begin
            case (haddr)
                OFF_CTRL0:  hrdata <= ctrl0;
                OFF_CTRL4:  hrdata <= ctrl4;
                OFF_VCSR:   hrdata <= vcsr;
                OFF_FAULTS: hrdata <= faults;
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // gating decision, purely from current flags
    logic             take;      // instruction accepted
    logic             is_vec;    // any vector-unit kind
    logic [5:0]       masks;     // condition masks
    logic [5:0]       hits;      // conditions that count
    logic [5:0]       unmasked;  // conditions that fault
    fault_t           next_fault;
    logic             next_default;

    assign take   = issue_valid && !xfer_busy;
    assign is_vec = issue_kind != KIND_LEGACY;
    assign masks  = vcsr[VCS_MASK_LSB +: NUM_COND];
    // integer vector and legacy ops never count a condition [RL1]
    assign hits   = (issue_kind == KIND_VEC_FP) ? issue_cond : 6'h00;
    assign unmasked = hits & ~masks;  // per-condition mask [RL2]

    always_comb begin
        next_fault   = FAULT_NONE;
        next_default = 1'b0;
        if (ctrl0[BIT_EMULATE] && is_vec) begin
            // emulate wins over switched flag [RL6] [RL20]
            next_fault = FAULT_UNDEF;
        end else if (ctrl0[BIT_SWITCHED] || ctrl0[BIT_EMULATE]) begin
            // fault before execution [RL7] [RL21]
            next_fault = FAULT_UNAVAIL;
        end else if (unmasked != 6'h00) begin
            // select flag and pin not consulted [RL5] [RL4]
            next_fault = ctrl4[BIT_OS_HNDL] ? FAULT_VEC_FP
                                            : FAULT_UNDEF;  // [RL19]
        end else begin
            // masked conditions complete with default value [RL3]
            next_default = hits != 6'h00;
        end
    end

    // outcome flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid   <= 1'b0;
            out_fault   <= FAULT_NONE;
            out_commit  <= 1'b0;
            out_default <= 1'b0;
        end else begin
            out_valid   <= take;
            out_fault   <= take ? next_fault : FAULT_NONE; // [RL8]
            // faulting instruction never commits [RL22]
            out_commit  <= take && next_fault == FAULT_NONE;
            out_default <= take && next_default;
        end
    end

    // fault record: code in low bits, count above
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faults <= 32'h0000_0000;
        end else if (take && next_fault != FAULT_NONE) begin
            faults <= {faults[31:16] + 16'h0001, 13'h0000, next_fault};
        end
    end

    // ==========================================================
    // control registers; hardware set beats any clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0 <= CTRL0_RESET;
        end else begin
            logic [31:0] v;
            v = ctrl0;
            if (ph_wr && ph_addr == OFF_CTRL0) begin
                v = hwdata;
            end
            if (mov_cr0_valid) begin
                v = mov_cr0_data;                 // [RL10]
            end
            if (clear_switched_flag_op_valid) begin
                v[BIT_SWITCHED] = 1'b0;
            end
            if (hw_task_switch) begin
                v[BIT_SWITCHED] = 1'b1;           // [RL9]
            end
            ctrl0 <= v;
        end
    end

    // handler-present flag written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl4 <= CTRL4_RESET;
        end else if (ph_wr && ph_addr == OFF_CTRL4) begin
            ctrl4 <= hwdata;
        end
    end

    // ==========================================================
    // full-state transfer sequencer [RL13]
    seq_state_t  seq;
    logic [3:0]  item;       // current item
    logic        store_dir;  // 1 save, 0 restore
    logic        start;      // accepted save/restore

    assign start = take && next_fault == FAULT_NONE &&
                   (issue_kind == KIND_SAVE ||
                    issue_kind == KIND_RESTORE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq       <= SEQ_IDLE;
            item      <= 4'h0;
            store_dir <= 1'b0;
        end else begin
            case (seq)
                SEQ_IDLE: begin
                    if (start) begin
                        seq       <= SEQ_RUN;
                        item      <= 4'h0;
                        store_dir <= issue_kind == KIND_SAVE;
                    end
                end
                SEQ_RUN: begin
                    // eight vectors, status, then scalar state
                    if (item == XFER_SCL_ITEM) begin
                        seq <= SEQ_IDLE;
                    end
                    item <= item + 4'h1;
                end
                default: seq <= SEQ_IDLE;
            endcase
        end
    end

    // transfer port flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_busy  <= 1'b0;
            xfer_valid <= 1'b0;
            xfer_store <= 1'b0;
            xfer_item  <= 4'h0;
            xfer_wdata <= 32'h0000_0000;
        end else begin
            xfer_busy  <= start ||
                (seq == SEQ_RUN && item != XFER_SCL_ITEM);
            xfer_valid <= seq == SEQ_RUN;
            xfer_store <= seq == SEQ_RUN && store_dir;
            xfer_item  <= item;
            xfer_wdata <= (item == XFER_VCS_ITEM) ? vcsr
                                                  : 32'h0000_0000;
        end
    end

    // ==========================================================
    // vector status: bus, restore load, sticky conditions (set wins)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vcsr <= VCSR_RESET;
        end else begin
            logic [31:0] v;
            v = vcsr;
            if (ph_wr && ph_addr == OFF_VCSR) begin
                v = hwdata & VCSR_WMASK;
            end
            if (xfer_valid && !xfer_store &&
                xfer_item == XFER_VCS_ITEM) begin
                v = xfer_rdata & VCSR_WMASK;
            end
            // only after gating passed [RL22]
            if (take && !ctrl0[BIT_EMULATE] && !ctrl0[BIT_SWITCHED]) begin
                v[VCS_FLAG_LSB +: NUM_COND] =
                    v[VCS_FLAG_LSB +: NUM_COND] | hits;
            end
            vcsr <= v;
        end
    end

    // ==========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic open_gate;
    assign open_gate = !ctrl0[BIT_EMULATE] && !ctrl0[BIT_SWITCHED];

    // ten items back to back, then the port falls quiet
    sequence s_xfer_run;
        xfer_valid [*8] ##1 xfer_valid ##1 xfer_valid ##1 !xfer_valid;
    endsequence

    // gating outcome per instruction kind, control flag side effects
    a_int_no_cond: assert property ( // [RL1]
        take && issue_kind == KIND_VEC_INT && open_gate
        |=> out_fault == FAULT_NONE && !out_default && out_commit)
        else $error("integer vector op raised a condition");
    a_mask_default: assert property ( // [RL3]
        take && issue_kind == KIND_VEC_FP && open_gate &&
        issue_cond != 6'h00 && (issue_cond & ~masks) == 6'h00
        |=> out_default && out_commit)
        else $error("masked condition did not complete");
    a_unmask_fault: assert property ( // [RL4]
        take && issue_kind == KIND_VEC_FP && open_gate &&
        (issue_cond & ~masks) != 6'h00 && ctrl4[BIT_OS_HNDL]
        |=> out_fault == FAULT_VEC_FP && !out_commit)
        else $error("unmasked condition gave no vector fault");
    a_no_handler: assert property ( // [RL19]
        take && issue_kind == KIND_VEC_FP && open_gate &&
        (issue_cond & ~masks) != 6'h00 && !ctrl4[BIT_OS_HNDL]
        |=> out_fault == FAULT_UNDEF)
        else $error("missing handler did not give undefined opcode");
    a_emulate_ud: assert property ( // [RL6]
        take && is_vec && ctrl0[BIT_EMULATE]
        |=> out_fault == FAULT_UNDEF && !out_commit)
        else $error("emulate flag did not block vector op");
    a_switched_nm: assert property ( // [RL7]
        take && ctrl0[BIT_SWITCHED] && !ctrl0[BIT_EMULATE]
        |=> out_fault == FAULT_UNAVAIL && !out_commit)
        else $error("switched flag did not give unavailable fault");
    a_nm_cause: assert property ( // [RL8]
        out_fault == FAULT_UNAVAIL |-> $past(take) &&
        ($past(ctrl0[BIT_SWITCHED]) || $past(ctrl0[BIT_EMULATE])))
        else $error("unavailable fault without cause");
    a_hw_sets_ts: assert property ( // [RL9]
        hw_task_switch |=> ctrl0[BIT_SWITCHED])
        else $error("task switch did not set switched flag");
    a_mov_sets_ts: assert property ( // [RL10]
        mov_cr0_valid && mov_cr0_data[BIT_SWITCHED] && !clear_switched_flag_op_valid
        |=> ctrl0[BIT_SWITCHED])
        else $error("move to control register lost switched flag");
    a_fault_frozen: assert property ( // [RL22]
        take && !open_gate && !ph_wr && !xfer_valid |=> $stable(vcsr))
        else $error("blocked instruction changed status");
    // busy rises first, items show from the second cycle on
    a_save_walk: assert property ( // [RL13]
        start |=> ##1 s_xfer_run)
        else $error("full-state transfer not ten items");

    // detected conditions of a vector fp op reach the sticky flags whenever emulate and switched flags are clear
    a_cond_sticky: assert property ( // [RL2]
        take && issue_kind == KIND_VEC_FP && open_gate
        |=> (vcsr[VCS_FLAG_LSB +: NUM_COND] & $past(issue_cond))
            == $past(issue_cond))
        else $error("detected condition not recorded");
    // the vector fault only ever follows a vector fp op
    a_vec_fault_src: assert property ( // [RL1]
        out_fault == FAULT_VEC_FP |-> $past(take) &&
        $past(issue_kind) == KIND_VEC_FP)
        else $error("vector fault from a non fp op");
    // nothing that faults is allowed to commit
    a_commit_clean: assert property ( // [RL22]
        out_commit |-> out_fault == FAULT_NONE && out_valid)
        else $error("faulting instruction committed");
endmodule

/* test/test_simd_fp_fault_gating.sv */
/*
 * self-checking bench for the vector fault gate: a table of gating
 * cases, then control flag side effects, state transfer and reset.
 * assumes the design's package is compiled first and that the bus
 * hready is the slave's own hreadyout.
 */
module test_simd_fp_fault_gating import simd_fp_gate_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // stimulus and observation signals
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, mov_cr0_data, xfer_wdata, xfer_rdata;
    logic        issue_valid, hw_task_switch, mov_cr0_valid, clear_switched_flag_op_valid;
    kind_t       issue_kind;
    logic [5:0]  issue_cond;
    logic        out_valid, out_commit, out_default;
    fault_t      out_fault;
    logic        xfer_busy, xfer_valid, xfer_store;
    logic [3:0]  xfer_item;
    int          n_errors, comparisons, n_x;
    logic [31:0] rd;                      // last bus read
    logic [3:0]  x_item [16];             // captured transfer items
    logic [31:0] x_wd   [16];             // captured transfer data
    logic        x_st;                    // last transfer direction
    typedef struct {
        logic [31:0] c0, c4, vc;
        kind_t       k;
        logic [5:0]  cond;
        fault_t      f;
        logic        cm, df;
    } row_t;
    row_t rows [10];
    // ==========================================================
    // design under test, bus hready looped back
    simd_fp_gate u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid),
        .issue_kind(issue_kind), .issue_cond(issue_cond),
        .hw_task_switch(hw_task_switch), .mov_cr0_valid(mov_cr0_valid),
        .mov_cr0_data(mov_cr0_data), .clear_switched_flag_op_valid(clear_switched_flag_op_valid),
        .out_valid(out_valid), .out_fault(out_fault),
        .out_commit(out_commit), .out_default(out_default),
        .xfer_busy(xfer_busy), .xfer_valid(xfer_valid),
        .xfer_store(xfer_store), .xfer_item(xfer_item),
        .xfer_wdata(xfer_wdata), .xfer_rdata(xfer_rdata));
    // ==========================================================
    // clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // transfer monitor: records each item the sequencer presents
    always @(posedge clk) begin
        if (xfer_valid === 1'b1) begin
            if (n_x < 16) begin
                x_item[n_x] = xfer_item;
                x_wd[n_x] = xfer_wdata;
            end
            n_x++;
            x_st = xfer_store;
        end
    end
    // ==========================================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, seen,
                     exp);
        end
    endtask
    // one ahb-lite single transfer, address phase then data phase
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one instruction issue; outputs sampled in the cycle after
    task issue(input kind_t k, input logic [5:0] c);
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_kind <= k;
        issue_cond <= c;
        @(posedge clk);
        issue_valid <= 1'b0;
        issue_cond <= 6'h00;
        #1;
    endtask
    // single-cycle pulse on one or more control side-effect inputs
    task pulse(input logic ts, input logic mv, input logic cl);
        @(posedge clk);
        hw_task_switch <= ts;
        mov_cr0_valid <= mv;
        clear_switched_flag_op_valid <= cl;
        @(posedge clk);
        {hw_task_switch, mov_cr0_valid, clear_switched_flag_op_valid} <= 3'b000;
    endtask
    // bounded wait for the sequencer to go idle
    task wait_idle;
        int k;
        k = 0;
        while (xfer_busy !== 1'b0 && k < 40) begin
            @(posedge clk);
            k++;
        end
        #1;
    endtask
    // closing verdict
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
    // ==========================================================
    // main sequence
    initial begin
        {rst_n, hsel, hwrite, issue_valid, x_st} = 5'b0;
        {hw_task_switch, mov_cr0_valid, clear_switched_flag_op_valid} = 3'b000;
        haddr = 8'h00;
        htrans = 2'b00;
        hsize = 3'h2;
        {hwdata, mov_cr0_data} = 64'h0;
        xfer_rdata = 32'h0000_0a80;
        issue_kind = KIND_LEGACY;
        issue_cond = 6'h00;
        {n_errors, comparisons, n_x} = '0;
        rows = '{
            '{32'h0, 32'h400, 32'h0, KIND_VEC_FP, 6'h02, FAULT_VEC_FP, 0, 0},
            '{32'h0, 32'h400, 32'h1f80, KIND_VEC_FP, 6'h02, FAULT_NONE, 1, 1},
            '{32'h0, 32'h400, 32'h0, KIND_VEC_INT, 6'h3f, FAULT_NONE, 1, 0},
            '{32'h0, 32'h0, 32'h0, KIND_VEC_FP, 6'h01, FAULT_UNDEF, 0, 0},
            '{32'h4, 32'h400, 32'h0, KIND_VEC_FP, 6'h00, FAULT_UNDEF, 0, 0},
            '{32'hc, 32'h400, 32'h0, KIND_VEC_INT, 6'h00, FAULT_UNDEF, 0, 0},
            '{32'h8, 32'h400, 32'h0, KIND_VEC_FP, 6'h08, FAULT_UNAVAIL, 0, 0},
            '{32'h8, 32'h400, 32'h0, KIND_LEGACY, 6'h00, FAULT_UNAVAIL, 0, 0},
            '{32'h0, 32'h400, 32'h0, KIND_LEGACY, 6'h00, FAULT_NONE, 1, 0},
            '{32'h20, 32'h400, 32'h0, KIND_VEC_FP, 6'h10, FAULT_VEC_FP, 0, 0}};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped place, read-only fault record
        bus(1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b1, OFF_FAULTS, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            check(rd, 32'h0, "reset or unmapped read");
        end
        check(32'(hresp), 32'h0, "hresp");
        // gating table
        foreach (rows[i]) begin
            bus(1'b1, OFF_CTRL0, rows[i].c0);
            bus(1'b1, OFF_CTRL4, rows[i].c4);
            bus(1'b1, OFF_VCSR, rows[i].vc);
            issue(rows[i].k, rows[i].cond);
            check(32'(out_valid), 32'h1, "out_valid");
            check(32'(out_fault), 32'(rows[i].f), "fault");
            check(32'(out_commit), 32'(rows[i].cm), "commit");
            check(32'(out_default), 32'(rows[i].df), "default");
        end
        // a gated instruction leaves status untouched
        bus(1'b1, OFF_VCSR, 32'h0);
        bus(1'b1, OFF_CTRL0, 32'h8);
        issue(KIND_VEC_FP, 6'h3f);
        check(32'(out_fault), 32'(FAULT_UNAVAIL), "gated fault");
        bus(1'b0, OFF_VCSR, 32'h0);
        check(rd, 32'h0, "status after fault");
        // each condition masked on its own
        bus(1'b1, OFF_CTRL0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, OFF_VCSR, 32'h1 << (7 + i));
            issue(KIND_VEC_FP, 6'(1 << i));
            check(32'(out_default), 32'h1, "masked alone");
            bus(1'b1, OFF_VCSR, 32'h1f80 & ~(32'h1 << (7 + i)));
            issue(KIND_VEC_FP, 6'(1 << i));
            check(32'(out_fault), 32'(FAULT_VEC_FP), "unmasked alone");
        end
        bus(1'b0, OFF_FAULTS, 32'h0);
        check(rd & 32'h7, 32'(FAULT_VEC_FP), "fault record");
        // control flag side effects, set beats clear on one edge
        pulse(1'b1, 1'b0, 1'b0);
        bus(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h8, "task switch");
        pulse(1'b0, 1'b0, 1'b1);
        bus(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h0, "clear flag");
        mov_cr0_data <= 32'h0000_0028;
        pulse(1'b0, 1'b1, 1'b0);
        bus(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h28, "move to ctrl0");
        pulse(1'b1, 1'b0, 1'b1);
        bus(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h28, "switch beats clear");
        // a save under the switched flag starts no transfer
        issue(KIND_SAVE, 6'h00);
        check(32'(out_fault), 32'(FAULT_UNAVAIL), "save gated");
        @(posedge clk);
        #1;
        check(32'(xfer_busy), 32'h0, "no transfer");
        // full save: ten items in order, status on item 8
        bus(1'b1, OFF_CTRL0, 32'h0);
        bus(1'b1, OFF_VCSR, 32'h1f80);
        issue(KIND_SAVE, 6'h00);
        check(32'(xfer_busy), 32'h1, "busy");
        issue(KIND_VEC_INT, 6'h00);
        check(32'(out_valid), 32'h0, "refused while busy");
        wait_idle();
        check(32'(n_x), 32'd10, "save count");
        check(32'(x_st), 32'h1, "save direction");
        for (int i = 0; i < 10; i++) begin
            check(32'(x_item[i]), 32'(i), "item order");
            check(x_wd[i], (i == 8) ? 32'h1f80 : 32'h0, "save data");
        end
        // full restore reloads the status register
        n_x = 0;
        issue(KIND_RESTORE, 6'h00);
        wait_idle();
        check(32'(n_x), 32'd10, "restore count");
        check(32'(x_st), 32'h0, "restore direction");
        bus(1'b0, OFF_VCSR, 32'h0);
        check(rd, 32'h0000_0a80, "restored status");
        // second reset in mid-run
        bus(1'b1, OFF_CTRL0, 32'h0000_000c);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h0, "ctrl0 after reset");
        results();
    end
endmodule
